// ===== osc_ext_equipment.sv
`timescale 1ns/1ps
`default_nettype none

// Pull-ups on collectors, relay contact
module osc_ext_equipment (
    // From the block
    input wire logic oc_a_o,
    input wire logic oc_a_oe,
    input wire logic oc_b_o,
    input wire logic oc_b_oe,
    input wire logic relay_coil,
    // Levels the equipment reads
    output logic pin_a,
    output logic pin_b,
    output logic contact
);
    // Released collector reads the pull-up
    assign pin_a = oc_a_oe ? oc_a_o : 1'b1;
    assign pin_b = oc_b_oe ? oc_b_o : 1'b1;
    // Contact closes with the coil
    assign contact = relay_coil;
endmodule

`default_nettype wire

// ===== osc_output_status.sv
// What this block does
// - Codes 0-17/0-18; 0 off, 1 fwd, 2 rev
// - Code 3 follows fault state
// - Code 6 running at zero speed
// - Codes 7/8 output at upper/lower limit
// - Code 9 running, given at or below lower limit
// - Code 11 follows overload
// - Code 14 ready: no fault, bus ok, uninhibited
// - Code 15 fixed pulse per sequencer cycle
// - Code 16 fixed pulse per sequencer stage
// - Code 17 undervoltage plus lockout message
// - Code 18 forward run excluding forward jog
// - Open collector pulls low, else released
// - Level detector with percent hysteresis
// - Code 4 output freq, 10 given freq
// - Code 5 output within given plus/minus width
// - Counter clocked by sixth input only
// - Count hits reset value, clears, pulses
// - Detect asserts at value below reset, holds until clear
// - Run mask 16 bits, stop 9, default 0xFF
// - Run mask bits pick sixteen quantities
// - Stop mask bit 8 stage, above reserved
// - Shift key steps to next enabled item
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module osc_output_status #(
    parameter int PULSE_CYC = osc_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive status (same clock domain)
    input wire logic running,
    input wire logic run_forward,
    input wire logic run_reverse,
    input wire logic jogging,
    input wire logic fault,
    input wire logic overload,
    input wire logic bus_voltage_ok,
    input wire logic undervoltage,
    input wire logic run_inhibit,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] given_freq,
    input wire logic [15:0] upper_limit_freq,
    input wire logic [15:0] lower_limit_freq,
    input wire logic seq_cycle_done,
    input wire logic seq_stage_done,
    // Pins and keypad (asynchronous)
    input wire logic count_clock_input,
    input wire logic shift_key,
    // Open-collector outputs
    output logic open_collector_out_a_o,
    output logic open_collector_out_a_oe,
    output logic open_collector_out_b_o,
    output logic open_collector_out_b_oe,
    // Relay coil
    output logic relay_out,
    // Display
    output logic undervoltage_lockout_message,
    output logic [3:0] display_item
);

    initial begin
        if (PULSE_CYC < 1) $error("PULSE_CYC must be at least 1");
    end

    // Configuration registers
    logic [4:0] sel_a_ff; // Function code of output A
    logic [4:0] sel_b_ff; // Function code of output B
    logic [4:0] sel_r_ff; // Function code of relay
    logic [15:0] level_ff; // Level, 0.01 Hz units
    logic [9:0] hyst_ff; // Hysteresis, 0.1 percent of level
    logic [9:0] window_ff; // Reach width, 0.1 percent of max
    logic [15:0] cnt_reset_ff; // Counter reset value
    logic [15:0] cnt_detect_ff; // Counter detect value
    logic [15:0] run_mask_ff; // Run display mask
    logic [8:0] stop_mask_ff; // Stop display mask
    logic [15:0] maxfreq_ff; // Maximum frequency

    // Detector state
    logic lvl_out_ff; // Level detect on output frequency
    logic lvl_given_ff; // Level detect on given frequency
    logic reach_ff; // Reach window flag
    logic [15:0] count_ff; // Event count
    logic cnt_det_ff; // Detect latched
    logic cnt_rst_ff; // Reset indication

    // Synchronisers
    logic cnt_in_s1_ff, cnt_in_s2_ff, cnt_in_d_ff;
    logic key_s1_ff, key_s2_ff, key_d_ff;

    // Sequencer pulses
    logic seq_cycle_pulse, seq_stage_pulse;

    // Width limit guards for APB writes
    function automatic logic [4:0] clamp_sel(input logic [31:0] d, input logic [4:0] mx);
        clamp_sel = (d[31:5] == '0 && d[4:0] <= mx) ? d[4:0] : 5'h00;
    endfunction

    function automatic logic [9:0] clamp_pct(input logic [31:0] d);
        clamp_pct = (d[31:10] == '0 && d[9:0] <= osc_pkg::PCT_FULL) ? d[9:0] : osc_pkg::PCT_FULL;
    endfunction

    // Percent of a frequency, tenths of a percent
    function automatic logic [15:0] pct_of(input logic [15:0] f, input logic [9:0] p);
        logic [25:0] prod;
        prod = f * p;
        pct_of = 16'(prod / 26'(osc_pkg::PCT_FULL));
    endfunction

    // Status picked by a function code
    function automatic logic pick(input logic [4:0] code, input logic [19:0] st);
        pick = (code <= 5'd18) ? st[code] : 1'b0;
    endfunction

    wire apb_wr = psel && penable && pwrite;

    // Register writes; out of range codes store zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_a_ff <= osc_pkg::RST_SEL_OC;
            sel_b_ff <= osc_pkg::RST_SEL_OC;
            sel_r_ff <= osc_pkg::RST_SEL_RELAY;
            level_ff <= osc_pkg::RST_LEVEL;
            hyst_ff <= osc_pkg::RST_HYST;
            window_ff <= osc_pkg::RST_WINDOW;
            cnt_reset_ff <= osc_pkg::RST_CNT_RESET;
            cnt_detect_ff <= osc_pkg::RST_CNT_DETECT;
            run_mask_ff <= osc_pkg::RST_RUN_MASK;
            stop_mask_ff <= osc_pkg::RST_STOP_MASK;
            maxfreq_ff <= osc_pkg::RST_MAXFREQ;
        end else if (apb_wr) begin
            case (paddr)
                osc_pkg::OFS_SEL_OC_A: sel_a_ff <= clamp_sel(pwdata, osc_pkg::SEL_MAX_OC);
                osc_pkg::OFS_SEL_OC_B: sel_b_ff <= clamp_sel(pwdata, osc_pkg::SEL_MAX_OC);
                osc_pkg::OFS_SEL_RELAY: sel_r_ff <= clamp_sel(pwdata, osc_pkg::SEL_MAX_RELAY);
                osc_pkg::OFS_LEVEL: level_ff <= pwdata[15:0];
                osc_pkg::OFS_HYST: hyst_ff <= clamp_pct(pwdata);
                osc_pkg::OFS_WINDOW: window_ff <= clamp_pct(pwdata);
                osc_pkg::OFS_CNT_RESET: cnt_reset_ff <= pwdata[15:0];
                osc_pkg::OFS_CNT_DETECT: begin
                    // Detect value may not pass the reset value
                    cnt_detect_ff <= (pwdata[15:0] > cnt_reset_ff) ? cnt_reset_ff : pwdata[15:0];
                end
                osc_pkg::OFS_RUN_MASK: run_mask_ff <= pwdata[15:0];
                osc_pkg::OFS_STOP_MASK: stop_mask_ff <= pwdata[8:0];
                osc_pkg::OFS_MAXFREQ: maxfreq_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Read mux; status word shows detector state and count
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            osc_pkg::OFS_SEL_OC_A: rd_mux = {27'h0, sel_a_ff};
            osc_pkg::OFS_SEL_OC_B: rd_mux = {27'h0, sel_b_ff};
            osc_pkg::OFS_SEL_RELAY: rd_mux = {27'h0, sel_r_ff};
            osc_pkg::OFS_LEVEL: rd_mux = {16'h0, level_ff};
            osc_pkg::OFS_HYST: rd_mux = {22'h0, hyst_ff};
            osc_pkg::OFS_WINDOW: rd_mux = {22'h0, window_ff};
            osc_pkg::OFS_CNT_RESET: rd_mux = {16'h0, cnt_reset_ff};
            osc_pkg::OFS_CNT_DETECT: rd_mux = {16'h0, cnt_detect_ff};
            osc_pkg::OFS_RUN_MASK: rd_mux = {16'h0, run_mask_ff};
            osc_pkg::OFS_STOP_MASK: rd_mux = {23'h0, stop_mask_ff};
            osc_pkg::OFS_MAXFREQ: rd_mux = {16'h0, maxfreq_ff};
            osc_pkg::OFS_STATUS: begin
                rd_mux[osc_pkg::STB_LEVEL_OUT] = lvl_out_ff;
                rd_mux[osc_pkg::STB_LEVEL_GIVEN] = lvl_given_ff;
                rd_mux[osc_pkg::STB_REACH] = reach_ff;
                rd_mux[osc_pkg::STB_CNT_DET] = cnt_det_ff;
                rd_mux[osc_pkg::STB_OUT_A] = open_collector_out_a_oe;
                rd_mux[osc_pkg::STB_OUT_B] = open_collector_out_b_oe;
                rd_mux[osc_pkg::STB_RELAY] = relay_out;
                rd_mux[31:16] = count_ff;
            end
            osc_pkg::OFS_DISPLAY: rd_mux = {28'h0, display_item};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero-wait APB answer; unmapped flags error
    wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= osc_pkg::OFS_DISPLAY);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Level thresholds; hysteresis is a share of level
    wire [15:0] hyst_amt = pct_of(level_ff, hyst_ff);
    wire [15:0] low_thr = (hyst_amt > level_ff) ? 16'h0000 : level_ff - hyst_amt;

    // Hysteretic level detectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_out_ff <= 1'b0;
            lvl_given_ff <= 1'b0;
        end else begin
            if (output_freq > level_ff) lvl_out_ff <= 1'b1;
            else if (output_freq < low_thr) lvl_out_ff <= 1'b0;
            if (given_freq > level_ff) lvl_given_ff <= 1'b1;
            else if (given_freq < low_thr) lvl_given_ff <= 1'b0;
        end
    end

    // Reach window around given frequency
    wire [15:0] win_amt = pct_of(maxfreq_ff, window_ff);
    wire [16:0] f_diff = (output_freq >= given_freq) ? {1'b0, output_freq - given_freq}
                                                    : {1'b0, given_freq - output_freq};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reach_ff <= 1'b0;
        end else begin
            reach_ff <= (f_diff <= {1'b0, win_amt});
        end
    end

    // Count input and shift key synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_in_s1_ff <= 1'b0;
            cnt_in_s2_ff <= 1'b0;
            cnt_in_d_ff <= 1'b0;
            key_s1_ff <= 1'b0;
            key_s2_ff <= 1'b0;
            key_d_ff <= 1'b0;
        end else begin
            cnt_in_s1_ff <= count_clock_input;
            cnt_in_s2_ff <= cnt_in_s1_ff;
            cnt_in_d_ff <= cnt_in_s2_ff;
            key_s1_ff <= shift_key;
            key_s2_ff <= key_s1_ff;
            key_d_ff <= key_s2_ff;
        end
    end

    wire cnt_rise = cnt_in_s2_ff && !cnt_in_d_ff;
    wire key_press = key_s2_ff && !key_d_ff;
    wire [15:0] count_inc = count_ff + 16'h0001;

    // Event counter; reset flag lasts while input is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 16'h0000;
            cnt_det_ff <= 1'b0;
            cnt_rst_ff <= 1'b0;
        end else begin
            if (!cnt_in_s2_ff) cnt_rst_ff <= 1'b0;
            if (cnt_rise) begin
                if (count_inc >= cnt_reset_ff) begin
                    count_ff <= 16'h0000;
                    cnt_rst_ff <= 1'b1;
                    cnt_det_ff <= 1'b0;
                end else begin
                    count_ff <= count_inc;
                    if (count_inc >= cnt_detect_ff) cnt_det_ff <= 1'b1;
                end
            end
        end
    end

    // Fixed width sequencer indications
    osc_pulse_stretch #(.WIDTH(PULSE_CYC)) u_cycle_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .trig(seq_cycle_done),
        .pulse(seq_cycle_pulse)
    );

    osc_pulse_stretch #(.WIDTH(PULSE_CYC)) u_stage_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .trig(seq_stage_done),
        .pulse(seq_stage_pulse)
    );

    // Status vector indexed by function code
    logic [19:0] st;
    always_comb begin
        st = 20'h0_0000;
        st[1] = running && run_forward;
        st[2] = running && run_reverse;
        st[3] = fault;
        st[4] = lvl_out_ff;
        st[5] = reach_ff;
        st[6] = running && (output_freq == 16'h0000);
        st[7] = output_freq == upper_limit_freq;
        st[8] = output_freq == lower_limit_freq;
        st[9] = running && (given_freq <= lower_limit_freq);
        st[10] = lvl_given_ff;
        st[11] = overload;
        st[12] = cnt_det_ff;
        st[13] = cnt_rst_ff;
        st[14] = !fault && bus_voltage_ok && !run_inhibit;
        st[15] = seq_cycle_pulse;
        st[16] = seq_stage_pulse;
        st[17] = undervoltage;
        st[18] = running && run_forward && !jogging;
    end

    // Registered physical outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_collector_out_a_o <= 1'b0;
            open_collector_out_a_oe <= 1'b0;
            open_collector_out_b_o <= 1'b0;
            open_collector_out_b_oe <= 1'b0;
            relay_out <= 1'b0;
            undervoltage_lockout_message <= 1'b0;
        end else begin
            // Active pulls the pin low, inactive releases it
            open_collector_out_a_o <= 1'b0;
            open_collector_out_b_o <= 1'b0;
            open_collector_out_a_oe <= pick(sel_a_ff, st);
            open_collector_out_b_oe <= pick(sel_b_ff, st);
            relay_out <= pick(sel_r_ff, st);
            undervoltage_lockout_message <= undervoltage;
        end
    end

    // Display mask: run uses 16 bits, stop only 9
    wire [15:0] act_mask = running ? run_mask_ff : {7'h00, stop_mask_ff};

    // Next enabled item, wrapping
    function automatic logic [3:0] next_item(input logic [3:0] cur, input logic [15:0] m);
        logic [3:0] idx;
        next_item = cur;
        for (int i = 1; i <= 16; i++) begin
            idx = 4'(cur + 4'(i));
            if (m[idx] && next_item == cur && i != 16) next_item = idx;
        end
        if (next_item == cur && !m[cur]) next_item = 4'h0;
    endfunction

    // Shift key advances the shown item
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_item <= 4'h0;
        end else if (key_press) begin
            display_item <= next_item(display_item, act_mask);
        end else if (!act_mask[display_item]) begin
            display_item <= next_item(display_item, act_mask);
        end
    end

endmodule

`default_nettype wire

// ===== osc_output_status_sva.sv
`timescale 1ns/1ps
`default_nettype none

module osc_output_status_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Drive status
    input wire logic running,
    input wire logic run_forward,
    input wire logic jogging,
    input wire logic fault,
    input wire logic overload,
    input wire logic bus_voltage_ok,
    input wire logic undervoltage,
    input wire logic run_inhibit,
    input wire logic [15:0] output_freq,
    // Outputs
    input wire logic open_collector_out_a_o,
    input wire logic open_collector_out_a_oe,
    input wire logic open_collector_out_b_o,
    input wire logic relay_out,
    input wire logic undervoltage_lockout_message
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed write on the bus
    wire wr_go = psel && penable && pwrite && pready;

    // Shadow selections, clamped
    logic [4:0] sel_a_ff;
    logic [4:0] sel_r_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_a_ff <= osc_pkg::RST_SEL_OC;
            sel_r_ff <= osc_pkg::RST_SEL_RELAY;
        end else if (wr_go && paddr == osc_pkg::OFS_SEL_OC_A) begin
            sel_a_ff <= (pwdata > 32'(osc_pkg::SEL_MAX_OC)) ? 5'h00 : pwdata[4:0];
        end else if (wr_go && paddr == osc_pkg::OFS_SEL_RELAY) begin
            sel_r_ff <= (pwdata > 32'(osc_pkg::SEL_MAX_RELAY)) ? 5'h00 : pwdata[4:0];
        end
    end

    a_no_output:
    assert property ($past(sel_a_ff) == 5'h00 |-> !open_collector_out_a_oe) else $error("A active at code 0");
    a_relay_fwd:
    assert property ($past(sel_r_ff) == 5'h01 |-> relay_out == $past(running && run_forward))
        else $error("relay fwd wrong");
    a_fault_follow:
    assert property ($past(sel_a_ff) == 5'h03 |-> open_collector_out_a_oe == $past(fault)) else $error("fault wrong");
    a_zero_speed:
    assert property ($past(sel_a_ff) == 5'h06 |-> open_collector_out_a_oe == ($past(running)
        && $past(output_freq) == 16'h0000)) else $error("zero speed wrong");
    a_overload_follow:
    assert property ($past(sel_a_ff) == 5'h0B |-> open_collector_out_a_oe == $past(overload))
        else $error("overload wrong");
    a_ready_ind:
    assert property ($past(sel_a_ff) == 5'h0E |-> open_collector_out_a_oe == (!$past(fault)
        && $past(bus_voltage_ok) && !$past(run_inhibit))) else $error("ready wrong");
    a_uvlo_msg:
    assert property (undervoltage_lockout_message == $past(undervoltage))
        else $error("lockout wrong");
    a_fwd_nojog:
    assert property ($past(sel_r_ff) == 5'h12 |-> relay_out == $past(running && run_forward && !jogging))
        else $error("fwd no jog wrong");
    a_oc_drive_low:
    assert property (!open_collector_out_a_o && !open_collector_out_b_o) else $error("collector driven high");
    a_apb_answer:
    assert property (psel && !penable |=> pready) else $error("no ready");
endmodule

bind osc_output_status osc_output_status_sva chk_u (.*);

`default_nettype wire

// ===== osc_pkg.sv
package osc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SEL_OC_A = 8'h00;
    localparam logic [7:0] OFS_SEL_OC_B = 8'h04;
    localparam logic [7:0] OFS_SEL_RELAY = 8'h08;
    localparam logic [7:0] OFS_LEVEL = 8'h0C;
    localparam logic [7:0] OFS_HYST = 8'h10;
    localparam logic [7:0] OFS_WINDOW = 8'h14;
    localparam logic [7:0] OFS_CNT_RESET = 8'h18;
    localparam logic [7:0] OFS_CNT_DETECT = 8'h1C;
    localparam logic [7:0] OFS_RUN_MASK = 8'h20;
    localparam logic [7:0] OFS_STOP_MASK = 8'h24;
    localparam logic [7:0] OFS_MAXFREQ = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_DISPLAY = 8'h30;

    // Reset values
    localparam logic [4:0] RST_SEL_OC = 5'h00;
    localparam logic [4:0] RST_SEL_RELAY = 5'h01;
    localparam logic [15:0] RST_LEVEL = 16'h1388;
    localparam logic [9:0] RST_HYST = 10'h032;
    localparam logic [9:0] RST_WINDOW = 10'h3E8;
    localparam logic [15:0] RST_CNT_RESET = 16'h0001;
    localparam logic [15:0] RST_CNT_DETECT = 16'h0001;
    localparam logic [15:0] RST_RUN_MASK = 16'h00FF;
    localparam logic [8:0] RST_STOP_MASK = 9'h0FF;
    localparam logic [15:0] RST_MAXFREQ = 16'h1388;

    // Selection code limits
    localparam logic [4:0] SEL_MAX_OC = 5'h11;
    localparam logic [4:0] SEL_MAX_RELAY = 5'h12;

    // Percent scale: tenths of a percent
    localparam logic [9:0] PCT_FULL = 10'h3E8;

    // Pulse width of sequencer indications
    localparam int PULSE_MS = 500;
    localparam int CLK_HZ = 40_000_000;
    localparam int PULSE_CYC = (PULSE_MS * (CLK_HZ / 1000));

    // Status register bit positions
    localparam int STB_LEVEL_OUT = 0;
    localparam int STB_LEVEL_GIVEN = 1;
    localparam int STB_REACH = 2;
    localparam int STB_CNT_DET = 3;
    localparam int STB_OUT_A = 4;
    localparam int STB_OUT_B = 5;
    localparam int STB_RELAY = 6;
    localparam int STB_COUNT = 16;

endpackage

// ===== osc_pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none

// Fixed-width pulse per event; retrigger restarts it
module osc_pulse_stretch #(
    parameter int WIDTH = 20_000_000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event in, pulse out
    input wire logic trig,
    output logic pulse
);

    localparam int CW = $clog2(WIDTH + 1);

    initial begin
        if (WIDTH < 1) $error("WIDTH must be at least 1");
    end

    logic [CW-1:0] cnt_ff; // Remaining cycles of the pulse

    // Load on event, count down to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (trig) begin
            cnt_ff <= CW'(WIDTH);
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign pulse = (cnt_ff != '0);

endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Clock, reset, bus
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr;
    // Status: run, fwd, rev, jog, fault, overload, bus ok, undervolt, inhibit
    logic [8:0] st = 9'h000;
    logic [15:0] of = 16'h0000, gf = 16'h0000, ul = 16'h0003, ll = 16'h0001;
    logic [1:0] sq = 2'b00;
    logic cnt = 1'b0, sh = 1'b0;
    logic oa_o, oa_oe, ob_o, ob_oe, rly_coil, msg, pin_a, pin_b, rly;
    logic [3:0] item;
    // Expected read results, oldest first
    logic [32:0] exq[$];
    logic [32:0] e_m;
    logic [31:0] rv [11];
    logic [4:0] codes [12];
    int n_mismatch = 0, n_compared = 0, n_cyc = 0, seed = 11, k;

    // Short pulse width keeps the run brief
    osc_output_status #(.PULSE_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .running(st[0]), .run_forward(st[1]), .run_reverse(st[2]), .jogging(st[3]), .fault(st[4]),
        .overload(st[5]), .bus_voltage_ok(st[6]), .undervoltage(st[7]), .run_inhibit(st[8]),
        .output_freq(of), .given_freq(gf), .upper_limit_freq(ul), .lower_limit_freq(ll),
        .seq_cycle_done(sq[0]), .seq_stage_done(sq[1]), .count_clock_input(cnt), .shift_key(sh),
        .open_collector_out_a_o(oa_o), .open_collector_out_a_oe(oa_oe), .open_collector_out_b_o(ob_o),
        .open_collector_out_b_oe(ob_oe), .relay_out(rly_coil), .undervoltage_lockout_message(msg),
        .display_item(item));
    osc_ext_equipment eq_u (.oc_a_o(oa_o), .oc_a_oe(oa_oe), .oc_b_o(ob_o), .oc_b_oe(ob_oe),
        .relay_coil(rly_coil), .pin_a(pin_a), .pin_b(pin_b), .contact(rly));

    // 40 MHz
    always #12.5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic pin(input string nm, input logic s, input logic e);
        chk(nm, 32'(s), 32'(e));
    endtask

    // One bus transfer; reads queue their expectation
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b0, a, 32'h0000_0000, {err, d});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Output each tested function code should give for the present status
    function automatic logic fexp(input logic [4:0] c);
        logic [18:0] v;
        v = {st[0] && st[1] && !st[3], st[7], 2'b00, !st[4] && st[6] && !st[8], 2'b00, st[5], 1'b0,
            st[0] && gf <= ll, of == ll, of == ul, st[0] && of == 16'h0000, 2'b00, st[4], st[0] && st[2],
            st[0] && st[1], 1'b0};
        fexp = v[c];
    endfunction

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Checks each read against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e_m = exq.pop_front();
            chk("prdata", prdata, e_m[31:0]);
            pin("pslverr", pslverr, e_m[32]);
        end
    end

    // Hang guard
    always @(posedge pclk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        rv = '{32'(osc_pkg::RST_SEL_OC), 32'(osc_pkg::RST_SEL_OC), 32'(osc_pkg::RST_SEL_RELAY),
            32'(osc_pkg::RST_LEVEL), 32'(osc_pkg::RST_HYST), 32'(osc_pkg::RST_WINDOW),
            32'(osc_pkg::RST_CNT_RESET), 32'(osc_pkg::RST_CNT_DETECT), 32'(osc_pkg::RST_RUN_MASK),
            32'(osc_pkg::RST_STOP_MASK), 32'(osc_pkg::RST_MAXFREQ)};
        codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0E, 5'h11, 5'h12};
        cyc(16);
        presetn <= 1'b1;
        // Reset values, holes and clamped codes
        for (int i = 0; i < 11; i++) rd(8'(4 * i), rv[i], 1'b0);
        rd(8'h34, 32'h0000_0000, 1'b1);
        rd(8'h02, 32'h0000_0000, 1'b1);
        wr(8'h00, 32'h0000_0012);
        rd(8'h00, 32'h0000_0000, 1'b0);
        wr(8'h08, 32'h0000_0012);
        rd(8'h08, 32'h0000_0012, 1'b0);
        // Random status against random codes
        for (int i = 0; i < 40; i++) begin
            k = {$random(seed)} % 12;
            wr(8'h08, 32'(codes[k]));
            wr(8'h00, 32'(codes[k % 11]));
            st <= 9'($random(seed));
            of <= 16'({$random(seed)} % 3);
            gf <= 16'({$random(seed)} % 3);
            cyc(3);
            pin("relay", rly, fexp(codes[k]));
            pin("pin_a", pin_a, !fexp(codes[k % 11]));
            pin("uvlo_msg", msg, st[7]);
        end
        // Level detector: 1000 with 10 percent hysteresis
        wr(8'h00, 32'h0000_0004);
        wr(8'h04, 32'h0000_000A);
        wr(8'h0C, 32'h0000_03E8);
        wr(8'h10, 32'h0000_0064);
        for (int i = 0; i < 5; i++) begin
            of <= 16'({16'h03E9, 16'h03E8, 16'h0383, 16'h03B6, 16'h03E9} >> (16 * i));
            gf <= (i == 0) ? 16'h0000 : of;
            cyc(3);
            pin("lvl_out", pin_a, !(i < 2 || i == 4));
            pin("lvl_given", pin_b, !(i == 1 || i == 2));
        end
        // Reach window: 10 percent of 5000 around 2000
        wr(8'h00, 32'h0000_0005);
        wr(8'h14, 32'h0000_0064);
        gf <= 16'h07D0;
        for (int i = 0; i < 4; i++) begin
            of <= 16'({16'h0A28, 16'h0960, 16'h0640, 16'h0578} >> (16 * i));
            cyc(3);
            pin("reach", pin_a, !(i == 1 || i == 2));
        end
        // Counter: reset at 4, detect at 2
        wr(8'h00, 32'h0000_000C);
        wr(8'h04, 32'h0000_000D);
        wr(8'h18, 32'h0000_0004);
        wr(8'h1C, 32'h0000_0002);
        for (int i = 1; i < 5; i++) begin
            cnt <= 1'b1;
            cyc(6);
            pin("cnt_det", pin_a, !(i >= 2 && i < 4));
            pin("cnt_rst", pin_b, i != 4);
            cnt <= 1'b0;
            cyc(6);
            pin("cnt_rst", pin_b, 1'b1);
        end
        // Sequencer pulses, each only on its own event
        wr(8'h08, 32'h0000_000F);
        wr(8'h04, 32'h0000_0010);
        for (int j = 1; j < 3; j++) begin
            sq <= 2'(j);
            cyc(1);
            sq <= 2'b00;
            cyc(3);
            pin("seq_cycle", rly, j == 1);
            pin("seq_stage", pin_b, j != 2);
            cyc(12);
            pin("seq_cycle", rly, 1'b0);
            pin("seq_stage", pin_b, 1'b1);
        end
        // Stop display: only items 2 and 8 enabled
        st <= 9'h040;
        wr(8'h24, 32'h0000_FF04);
        rd(8'h24, 32'h0000_0104, 1'b0);
        cyc(6);
        rd(8'h30, 32'h0000_0002, 1'b0);
        for (int j = 0; j < 2; j++) begin
            sh <= 1'b1;
            cyc(6);
            sh <= 1'b0;
            cyc(6);
            rd(8'h30, j ? 32'h0000_0002 : 32'h0000_0008, 1'b0);
        end
        cyc(3);
        report_and_stop();
    end
endmodule

`default_nettype wire
